// [design/rsfs_pkg.sv]
// Constants and types shared by the regulator startup and fault sequencer
package rsfs_pkg;

    localparam int CLK_HZ = 20_000_000;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000;
    localparam int SS_TIME_MS = 14;
    localparam int FAULT_TIME_MS = 200;
    localparam int SS_CYCLES = SS_TIME_MS * CYCLES_PER_MS;
    localparam int FAULT_CYCLES = FAULT_TIME_MS * CYCLES_PER_MS;

    localparam int SS_STEPS = 128;
    localparam int STEP_W = 8;
    localparam int CNT_W = 24;
    localparam int DAC_W = 7;
    localparam int PEAK_CURRENT_LIMIT_W = 4;
    localparam int PROD_W = 15;
    localparam logic [STEP_W-1:0] STEP_LAST = 8'h80;
    localparam logic [PEAK_CURRENT_LIMIT_W-1:0] PEAK_CURRENT_LIMIT_FULL = 4'h8;
    localparam logic [DAC_W-1:0] DAC_ZERO = 7'h00;
    localparam logic [DAC_W-1:0] DAC_REF = 7'h7f;
    // 250mV against the 1.25V reference, 128 codes full scale
    localparam logic [DAC_W-1:0] GOFF_FINAL = 7'h1a;
    localparam logic [DAC_W-1:0] GOFF_SPAN = DAC_REF - GOFF_FINAL;

    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADR_W-1:0] OFS_MASK = 8'h04;
    localparam logic [ADR_W-1:0] OFS_STATE = 8'h08;

    localparam int EV_W = 4;
    localparam int EV_SS_DONE = 0;
    localparam int EV_SW_ON = 1;
    localparam int EV_TIMED_FAULT = 2;
    localparam int EV_THERMAL = 3;

    typedef enum logic [1:0] {
        SEQ_OFF,
        SEQ_SOFT,
        SEQ_RUN,
        SEQ_FAULT
    } rsfs_phase_type;

    typedef struct packed {
        logic uvloOk;
        logic refOk;
        logic boostInReg;
        logic boostLow;
        logic gonLow;
        logic goffLow;
        logic delayTripped;
        logic overTemp;
    } rsfs_sense_type;

    typedef struct packed {
        logic boostEn;
        logic gonEn;
        logic goffEn;
        logic [PEAK_CURRENT_LIMIT_W-1:0] peakCurrentLimit;
        logic [DAC_W-1:0] gonDac;
        logic [DAC_W-1:0] goffDac;
        logic delayChargeEn;
        logic delayShortEn;
        logic highSideSwitchOn;
        logic lowSideSwitchOn;
        logic ampEn;
    } rsfs_drive_type;

endpackage

// [design/rsfs_sequencer.sv]
// Regulator startup, switch control and fault latch sequencer
// Functional notes
// - Reference above threshold enables all three regulators together.
// - Step-up current limit rises from zero in eight equal steps.
// - Step-up soft-start ends at regulation or timer expiry, first wins.
// - Gate-on DAC ramps 7-bit code up over 128 steps.
// - Gate-off DAC ramps down over 128 steps to 250mV level.
// - Each soft-start lasts nominally 14ms.
// - Delay charge only with supply ok, soft-starts done, no fault.
// - Delay node shorted to ground before startup and under lockout.
// - Switch select ignored, switches off, until all four conditions.
// - Active and select high: high-side on, low-side off.
// - Active and select low: high-side off, low-side on.
// - Fault timer runs while any output is below fault threshold.
// - Uninterrupted fault for timer period latches shutdown.
// - Fault latch clears only by supply dropping below lockout.
// - Fault detection inhibited during soft-start.
// - Over-temperature sets fault latch immediately.
// - Lockout disables regulators, switches, amplifiers.
//
// Chosen here: the Wishbone slave port and the address map.
`timescale 1ns/10ps
`default_nettype none

module rsfs_sequencer #(
    parameter int SS_CYCLES = rsfs_pkg::SS_CYCLES,
    parameter int FAULT_CYCLES = rsfs_pkg::FAULT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire rsfs_pkg::rsfs_sense_type sense,
    input wire logic switchSelectInput,
    output rsfs_pkg::rsfs_drive_type drive,
    output logic faultLatched,
    output logic irq,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [rsfs_pkg::ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o
);

    // Truncating division: a step never runs long
    localparam int STEP_CYCLES = (SS_CYCLES / rsfs_pkg::SS_STEPS) < 1 ?
        1 : SS_CYCLES / rsfs_pkg::SS_STEPS;
    localparam logic [rsfs_pkg::CNT_W-1:0] STEP_END =
        rsfs_pkg::CNT_W'(STEP_CYCLES - 1);
    localparam logic [rsfs_pkg::CNT_W-1:0] FAULT_END =
        rsfs_pkg::CNT_W'(FAULT_CYCLES - 1);

    typedef struct packed {
        rsfs_pkg::rsfs_phase_type phase;
        logic [rsfs_pkg::STEP_W-1:0] stepIdx;
        logic [rsfs_pkg::CNT_W-1:0] tick;
        logic [rsfs_pkg::CNT_W-1:0] faultCnt;
        logic boostDone;
        logic faultLatch;
        logic swActive;
        logic [rsfs_pkg::EV_W-1:0] status;
        logic [rsfs_pkg::EV_W-1:0] mask;
        logic ack;
        logic [31:0] rdData;
        rsfs_pkg::rsfs_drive_type drive;
    } rsfs_state_type;

    rsfs_state_type state_reg;
    rsfs_state_type state_next;

    logic [rsfs_pkg::EV_W-1:0] ev;
    logic [rsfs_pkg::EV_W-1:0] clr;
    logic anyLow;
    logic running;
    logic [rsfs_pkg::PROD_W-1:0] goffProd;

    always_comb begin
        state_next = state_reg;
        ev = '0;
        clr = '0;
        anyLow = sense.boostLow | sense.gonLow | sense.goffLow;
        goffProd = '0;

        unique case (state_reg.phase)
            rsfs_pkg::SEQ_OFF: begin
                if (sense.refOk) begin
                    state_next.phase = rsfs_pkg::SEQ_SOFT;
                    state_next.stepIdx = '0;
                    state_next.tick = '0;
                    state_next.boostDone = 1'b0;
                end
            end
            rsfs_pkg::SEQ_SOFT: begin
                state_next.faultCnt = '0;
                if (state_reg.tick == STEP_END) begin
                    state_next.tick = '0;
                    state_next.stepIdx = state_reg.stepIdx + 1'b1;
                end else begin
                    state_next.tick = state_reg.tick + 1'b1;
                end
                if (sense.boostInReg) begin
                    state_next.boostDone = 1'b1;
                end
                if (state_reg.stepIdx == rsfs_pkg::STEP_LAST) begin
                    state_next.phase = rsfs_pkg::SEQ_RUN;
                    state_next.stepIdx = rsfs_pkg::STEP_LAST;
                    state_next.boostDone = 1'b1;
                    ev[rsfs_pkg::EV_SS_DONE] = 1'b1;
                end
            end
            rsfs_pkg::SEQ_RUN: begin
                if (anyLow) begin
                    if (state_reg.faultCnt == FAULT_END) begin
                        state_next.faultLatch = 1'b1;
                        state_next.phase = rsfs_pkg::SEQ_FAULT;
                        ev[rsfs_pkg::EV_TIMED_FAULT] = 1'b1;
                    end else begin
                        state_next.faultCnt = state_reg.faultCnt + 1'b1;
                    end
                end else begin
                    state_next.faultCnt = '0;
                end
            end
            rsfs_pkg::SEQ_FAULT: begin
                state_next.faultLatch = 1'b1;
            end
        endcase

        if (sense.overTemp) begin
            state_next.faultLatch = 1'b1;
            state_next.phase = rsfs_pkg::SEQ_FAULT;
            if (!state_reg.faultLatch) begin
                ev[rsfs_pkg::EV_THERMAL] = 1'b1;
            end
        end

        // Lockout is the only way out of the fault latch
        if (!sense.uvloOk) begin
            state_next.phase = rsfs_pkg::SEQ_OFF;
            state_next.faultLatch = 1'b0;
            state_next.stepIdx = '0;
            state_next.tick = '0;
            state_next.faultCnt = '0;
            state_next.boostDone = 1'b0;
            ev = '0;
        end

        running = state_next.phase == rsfs_pkg::SEQ_SOFT ||
            state_next.phase == rsfs_pkg::SEQ_RUN;
        state_next.swActive = sense.uvloOk && !state_next.faultLatch &&
            state_next.phase == rsfs_pkg::SEQ_RUN &&
            sense.delayTripped;
        if (state_next.swActive && !state_reg.swActive) begin
            ev[rsfs_pkg::EV_SW_ON] = 1'b1;
        end

        state_next.drive.boostEn = running;
        state_next.drive.gonEn = running;
        state_next.drive.goffEn = running;
        state_next.drive.peakCurrentLimit = '0;
        state_next.drive.gonDac = rsfs_pkg::DAC_ZERO;
        state_next.drive.goffDac = rsfs_pkg::DAC_ZERO;
        if (running) begin
            if (state_next.boostDone) begin
                state_next.drive.peakCurrentLimit = rsfs_pkg::PEAK_CURRENT_LIMIT_FULL;
            end else begin
                // Sixteen DAC steps per current-limit eighth
                state_next.drive.peakCurrentLimit =
                    state_next.stepIdx[7:4];
            end
            if (state_next.stepIdx[7]) begin
                state_next.drive.gonDac = rsfs_pkg::DAC_REF;
            end else begin
                state_next.drive.gonDac = state_next.stepIdx[6:0];
            end
            goffProd = rsfs_pkg::PROD_W'(state_next.stepIdx) *
                rsfs_pkg::PROD_W'(rsfs_pkg::GOFF_SPAN);
            state_next.drive.goffDac =
                rsfs_pkg::DAC_REF - goffProd[13:7];
        end
        state_next.drive.delayShortEn = !sense.uvloOk ||
            state_next.phase == rsfs_pkg::SEQ_OFF;
        state_next.drive.delayChargeEn = sense.uvloOk &&
            state_next.phase == rsfs_pkg::SEQ_RUN &&
            !state_next.faultLatch;
        state_next.drive.highSideSwitchOn =
            state_next.swActive && switchSelectInput;
        state_next.drive.lowSideSwitchOn =
            state_next.swActive && !switchSelectInput;
        state_next.drive.ampEn =
            sense.uvloOk && !state_next.faultLatch;

        // Single-cycle ack, dropped in the following cycle
        state_next.ack = cyc_i && stb_i && !state_reg.ack;
        if (state_next.ack) begin
            unique case (adr_i)
                rsfs_pkg::OFS_STATUS: begin
                    state_next.rdData = 32'(state_reg.status);
                end
                rsfs_pkg::OFS_MASK: begin
                    state_next.rdData = 32'(state_reg.mask);
                end
                rsfs_pkg::OFS_STATE: begin
                    state_next.rdData = {16'h0000,
                        state_reg.stepIdx,
                        3'h0,
                        state_reg.swActive,
                        state_reg.boostDone,
                        state_reg.faultLatch,
                        state_reg.phase};
                end
                default: begin
                    state_next.rdData = 32'h0000_0000;
                end
            endcase
        end
        if (state_reg.ack && we_i && sel_i[0]) begin
            if (adr_i == rsfs_pkg::OFS_STATUS) begin
                clr = dat_i[rsfs_pkg::EV_W-1:0];
            end
            if (adr_i == rsfs_pkg::OFS_MASK) begin
                state_next.mask = dat_i[rsfs_pkg::EV_W-1:0];
            end
        end
        // New events win over a clear in the same cycle
        state_next.status = (state_reg.status & ~clr) | ev;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= '0;
            state_reg.phase <= rsfs_pkg::SEQ_OFF;
            state_reg.drive.delayShortEn <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign drive = state_reg.drive;
    assign faultLatched = state_reg.faultLatch;
    assign irq = |(state_reg.status & state_reg.mask);
    assign dat_o = state_reg.rdData;
    assign ack_o = state_reg.ack;

    // Soft-start length observer for the checks below
    logic [rsfs_pkg::CNT_W-1:0] ssLen;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ssLen <= '0;
        end else if (state_reg.phase == rsfs_pkg::SEQ_SOFT) begin
            ssLen <= ssLen + 1'b1;
        end else begin
            ssLen <= '0;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    enables_together_a: assert property (
        $rose(drive.boostEn) |-> drive.gonEn && drive.goffEn &&
            $past(sense.refOk))
        else $error("regulator enables not simultaneous");

    peak_current_limit_step_a: assert property (
        state_reg.phase == rsfs_pkg::SEQ_SOFT && !state_reg.boostDone &&
            $past(state_reg.phase) == rsfs_pkg::SEQ_SOFT &&
            $changed(drive.peakCurrentLimit)
        |-> drive.peakCurrentLimit == $past(drive.peakCurrentLimit) + 1'b1)
        else $error("current limit step not one eighth");

    boost_release_a: assert property (
        state_reg.phase == rsfs_pkg::SEQ_SOFT && sense.boostInReg &&
            sense.uvloOk && !sense.overTemp
        |=> drive.peakCurrentLimit == rsfs_pkg::PEAK_CURRENT_LIMIT_FULL)
        else $error("full limit not released at regulation");

    gon_ramp_a: assert property (
        drive.gonEn && $past(drive.gonEn) && $changed(drive.gonDac)
        |-> drive.gonDac == $past(drive.gonDac) + 1'b1)
        else $error("gate-on code did not step by one");

    goff_final_a: assert property (
        state_reg.phase == rsfs_pkg::SEQ_RUN
        |-> drive.goffDac == rsfs_pkg::GOFF_FINAL &&
            drive.gonDac == rsfs_pkg::DAC_REF)
        else $error("final DAC codes wrong");

    soft_length_a: assert property (
        state_reg.phase == rsfs_pkg::SEQ_SOFT &&
            state_next.phase == rsfs_pkg::SEQ_RUN
        |-> ssLen == rsfs_pkg::CNT_W'(rsfs_pkg::SS_STEPS * STEP_CYCLES))
        else $error("soft-start length wrong");

    charge_gate_a: assert property (
        drive.delayChargeEn |-> $past(sense.uvloOk) &&
            !state_reg.faultLatch &&
            state_reg.phase == rsfs_pkg::SEQ_RUN)
        else $error("delay charge enabled too early");

    delay_short_a: assert property (
        !sense.uvloOk |=> drive.delayShortEn && !drive.delayChargeEn)
        else $error("delay node not shorted in lockout");

    switch_gate_a: assert property (
        drive.highSideSwitchOn || drive.lowSideSwitchOn
        |-> $past(sense.delayTripped) && !state_reg.faultLatch &&
            state_reg.phase == rsfs_pkg::SEQ_RUN)
        else $error("switch on before all conditions");

    switch_select_a: assert property (
        state_reg.swActive
        |-> drive.highSideSwitchOn == $past(switchSelectInput) &&
            drive.lowSideSwitchOn == !$past(switchSelectInput))
        else $error("switch does not follow select");

    timer_run_a: assert property (
        state_reg.phase == rsfs_pkg::SEQ_RUN && anyLow && sense.uvloOk &&
            !sense.overTemp && state_reg.faultCnt != FAULT_END
        |=> state_reg.faultCnt == $past(state_reg.faultCnt) + 1'b1)
        else $error("fault timer not running");

    latch_shutdown_a: assert property (
        state_reg.faultLatch
        |-> !drive.boostEn && !drive.gonEn && !drive.ampEn &&
            !drive.highSideSwitchOn && !drive.lowSideSwitchOn)
        else $error("latched fault left outputs on");

    latch_hold_a: assert property (
        state_reg.faultLatch && sense.uvloOk |=> state_reg.faultLatch)
        else $error("fault latch cleared without lockout");

    soft_inhibit_a: assert property (
        state_reg.phase == rsfs_pkg::SEQ_SOFT |-> state_reg.faultCnt == '0)
        else $error("fault timer ran in soft-start");

    thermal_latch_a: assert property (
        sense.overTemp && sense.uvloOk |=> state_reg.faultLatch)
        else $error("over-temperature did not latch");

    lockout_off_a: assert property (
        !sense.uvloOk |=> !drive.boostEn && !drive.gonEn &&
            !drive.goffEn && !drive.ampEn && !drive.highSideSwitchOn &&
            !drive.lowSideSwitchOn)
        else $error("outputs alive under lockout");

    lockout_restart_a: assert property (
        !sense.uvloOk |=> state_reg.phase == rsfs_pkg::SEQ_OFF &&
            !state_reg.faultLatch)
        else $error("lockout did not restart the sequence");

    timer_clear_a: assert property (
        state_reg.phase == rsfs_pkg::SEQ_RUN && !anyLow && sense.uvloOk
        |=> state_reg.faultCnt == '0)
        else $error("fault timer not restarted");

    soft_done_c: cover property (
        state_reg.phase == rsfs_pkg::SEQ_SOFT ##1
        state_reg.phase == rsfs_pkg::SEQ_RUN);
    switch_on_c: cover property ($rose(drive.highSideSwitchOn));
    timed_fault_c: cover property (
        state_reg.phase == rsfs_pkg::SEQ_RUN ##1 state_reg.faultLatch);
    restart_c: cover property (
        state_reg.faultLatch ##1 !state_reg.faultLatch);
    thermal_fault_c: cover property (
        sense.overTemp && sense.uvloOk ##1 state_reg.faultLatch);

endmodule

`default_nettype wire

// [dv/rsfs_analog_model.sv]
// Behavioural comparators and power stages facing the sequencer
`timescale 1ns/10ps
`default_nettype none

module rsfs_analog_model #(
    parameter int DELAY_CYC = 30
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire rsfs_pkg::rsfs_drive_type drive,
    input wire logic supplyOk,
    input wire logic refUp,
    input wire logic regulate,
    input wire logic [2:0] faultInj,
    input wire logic hot,
    output rsfs_pkg::rsfs_sense_type sense
);
    int chargeCnt;

    // Delay node only ramps while charged and not shorted
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chargeCnt <= 0;
        end else if (drive.delayShortEn) begin
            chargeCnt <= 0;
        end else if (drive.delayChargeEn && chargeCnt < DELAY_CYC) begin
            chargeCnt <= chargeCnt + 1;
        end
    end

    // A disabled output sits below its fault threshold
    always_comb begin
        sense.uvloOk = supplyOk;
        sense.refOk = refUp;
        sense.boostInReg = regulate & drive.boostEn;
        sense.boostLow = faultInj[0] | ~drive.boostEn;
        sense.gonLow = faultInj[1] | ~drive.gonEn;
        sense.goffLow = faultInj[2] | ~drive.goffEn;
        sense.delayTripped = (chargeCnt >= DELAY_CYC);
        sense.overTemp = hot;
    end
endmodule

`default_nettype wire

// [dv/tb_top.sv]
// Self-checking bench for the regulator startup and fault sequencer
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    localparam int SSC = 1280;
    localparam int FLT = 50;
    localparam int LIMIT = 20000;
    logic clk;
    logic rst_b;
    logic supplyOk;
    logic refUp;
    logic regulate;
    logic [2:0] faultInj;
    logic hot;
    logic switchSelectInput;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] datW;
    logic [31:0] datR;
    logic ack;
    logic faultLatched;
    logic irq;
    rsfs_pkg::rsfs_sense_type sense;
    rsfs_pkg::rsfs_drive_type drive;
    int errors;
    int cmp_count;
    int cycles;

    rsfs_sequencer #(.SS_CYCLES(SSC), .FAULT_CYCLES(FLT)) DUT (
        .clk(clk), .rst_b(rst_b), .sense(sense),
        .switchSelectInput(switchSelectInput), .drive(drive),
        .faultLatched(faultLatched), .irq(irq), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR),
        .ack_o(ack));

    rsfs_analog_model #(.DELAY_CYC(30)) partner (
        .clk(clk), .rst_b(rst_b), .drive(drive), .supplyOk(supplyOk),
        .refUp(refUp), .regulate(regulate), .faultInj(faultInj),
        .hot(hot), .sense(sense));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    task automatic complete_run;
        $display("Comparisons %0d, errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Slave latency is not assumed; only the run timeout ends a wait
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        datW <= d;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        q = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk(ack === 1'b1, "bus answer missing");
    endtask

    task automatic start_seq;
        @(posedge clk);
        supplyOk <= 1'b1;
        refUp <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(drive.boostEn & drive.gonEn & drive.goffEn, "enables");
    endtask

    // Linear ramp from the reference code down to the final code
    function automatic logic [6:0] goffExp(input int k);
        return 7'(rsfs_pkg::DAC_REF -
            ((k * (rsfs_pkg::DAC_REF - rsfs_pkg::GOFF_FINAL)) >> 7));
    endfunction

    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            $display("ERROR %0t run did not finish", $time);
            complete_run();
        end
    end

    initial begin
        logic [31:0] q;
        logic [1:0] sw;
        int n;
        int pick;
        int s;
        {rst_b, supplyOk, refUp, regulate, faultInj, hot} = '0;
        {switchSelectInput, cyc, stb, we, adr, datW} = '0;
        sel = 4'h1;
        errors = 0;
        cmp_count = 0;
        cycles = 0;
        q = $urandom(32'hc97e_514d);
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk(drive.delayShortEn === 1'b1 && !drive.boostEn, "rst");
        @(posedge clk);
        rst_b <= 1'b1;
        // Output fault held through the ramp until past step 100 must be ignored
        faultInj <= 3'b010;
        start_seq();
        chk(drive.gonDac === 7'h00, "gate-on start");
        n = 0;
        while (drive.delayChargeEn !== 1'b1 && n < 2000) begin
            // Step index expected from elapsed cycles alone
            s = n / (SSC / rsfs_pkg::SS_STEPS);
            chk(drive.gonDac === 7'((s > 127) ? 127 : s), "gon");
            chk(drive.peakCurrentLimit === 4'(s >> 4), "peak_current_limit");
            chk(drive.goffDac === goffExp(s), "goff");
            chk(faultLatched === 1'b0, "fault in soft-start");
            @(posedge clk);
            if (s > 100) faultInj <= 3'b000;
            @(negedge clk);
            n++;
        end
        chk(n >= 1270 && n <= 1295, "soft-start length");
        chk(drive.peakCurrentLimit === 4'h8, "peak_current_limit at expiry");
        chk(drive.gonDac === rsfs_pkg::DAC_REF, "gon end");
        chk(drive.goffDac === rsfs_pkg::GOFF_FINAL, "goff end");
        chk(drive.delayShortEn === 1'b0, "delay short in run");
        n = 0;
        while (sense.delayTripped !== 1'b1 && n < 100) begin
            sw = {drive.highSideSwitchOn, drive.lowSideSwitchOn};
            chk(sw === 2'b00, "switches held off");
            @(posedge clk);
            switchSelectInput <= 1'($urandom);
            @(negedge clk);
            n++;
        end
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            pick = (i < 2) ? i : $urandom;
            switchSelectInput <= pick[0];
            @(posedge clk);
            @(negedge clk);
            chk(drive.highSideSwitchOn === pick[0], "high switch");
            chk(drive.lowSideSwitchOn === !pick[0], "low switch");
        end
        wb(1'b0, rsfs_pkg::OFS_STATUS, 32'h0000_0000, q);
        chk(q[1:0] === 2'b11 && irq === 1'b0, "status before mask");
        wb(1'b1, rsfs_pkg::OFS_MASK, 32'h0000_000f, q);
        @(negedge clk);
        chk(irq === 1'b1, "irq unmasked");
        wb(1'b1, rsfs_pkg::OFS_STATUS, 32'h0000_0003, q);
        @(negedge clk);
        chk(irq === 1'b0, "irq cleared");
        wb(1'b0, 8'hfc, 32'h0000_0000, q);
        chk(q === 32'h0000_0000, "unmapped read");
        // Interrupted faults must restart the timer
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            faultInj <= 3'(1 << $urandom_range(2, 0));
            n = (i == 0) ? FLT - 2 : $urandom_range(FLT - 5, 5);
            repeat (n) @(posedge clk);
            faultInj <= 3'b000;
            repeat (3) @(negedge clk);
            chk(faultLatched === 1'b0, "short fault latched");
        end
        @(posedge clk);
        faultInj <= 3'b100;
        n = 0;
        while (faultLatched !== 1'b1 && n < 80) begin
            @(negedge clk);
            n++;
        end
        chk(n >= 49 && n <= 53, "fault timer length");
        @(negedge clk);
        chk(!(drive.boostEn | drive.gonEn | drive.goffEn | drive.ampEn |
            drive.highSideSwitchOn | drive.lowSideSwitchOn |
            drive.delayChargeEn), "outputs after latch");
        @(posedge clk);
        faultInj <= 3'b000;
        regulate <= 1'b1;
        wb(1'b1, rsfs_pkg::OFS_STATUS, 32'h0000_000f, q);
        refUp <= 1'b0;
        repeat (20) @(negedge clk);
        chk(faultLatched === 1'b1 && !drive.boostEn, "hold");
        @(posedge clk);
        supplyOk <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(!faultLatched && drive.delayShortEn, "uv");
        chk(!drive.ampEn && !drive.boostEn, "uv off");
        start_seq();
        n = 0;
        while (drive.peakCurrentLimit !== 4'h8 && n < 4) begin
            @(negedge clk);
            n++;
        end
        chk(n <= 2, "limit release at regulation");
        @(posedge clk);
        hot <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        chk(faultLatched === 1'b1, "thermal latch");
        @(negedge clk);
        chk(!drive.boostEn && !drive.gonEn, "thermal off");
        wb(1'b0, rsfs_pkg::OFS_STATUS, 32'h0000_0000, q);
        chk(q[3] === 1'b1 && irq === 1'b1, "thermal status");
        complete_run();
    end
endmodule

`default_nettype wire
